// File: verilog/cm_map_sid_decoder.sv
/*
  Cable-modem MAC front end: downstream address check, data PID filter with
  a 16-word byte FIFO, MAP element service ID classification, protocol
  timers and retry limits.
  Assumes every input comes from logic on CLK; the MAP parser presents one
  element per IE_VALID pulse with burst geometry relative to its start.
*/
`timescale 1ns/100ps
`default_nettype none
`include "cm_map_regs.svh"

// Overview of operation
// R1 - accept frames sent to all-modems address
// R2 - reserved multicast range frames are never bridged
// R3 - addresses compared in LSB-first wire order
// R4 - no-modem SID zero never allows transmit
// R5 - unranged modem identifies with SID zero
// R6 - all-modems SID is open contention
// R7 - size-limited SIDs valid only in request/data
// R8 - size-limited burst: offset multiple of N, N slots
// R9 - priority SID block only in request elements
// R10 - request only if own priority bit set
// R11 - pass payload only from data PID packets
// R12 - head end sends sync within 200 ms
// R13 - head end sends descriptors within 2 s
// R14 - head end maps at most 4096 slots ahead
// R15 - sync lost after 600 ms without sync
// R16 - ranging fails only after 16 retries
// R17 - bandwidth request dropped after 16 retries
// R18 - map elements decided well within 200 us
// R19 - head end allows 1 ms before invited ranging
// R20 - descriptor wait at most five descriptor intervals
// R21 - ranging wait at most five ranging intervals
// R22 - registration reply wait at most 3 s
// R23 - own unicast SID means dedicated grant
module cm_map_sid_decoder #(
  parameter int         NUM_SID        = 4,
  parameter int         FIFO_DEPTH     = 16,
  parameter logic [3:0] IUC_REQUEST    = 4'h1,
  parameter logic [3:0] IUC_REQ_DATA   = 4'h2,
  parameter logic [3:0] IUC_INIT_MAINT = 4'h3,
  parameter logic [31:0] SYNC_LOSS_CYC = 32'(`SYNC_LOSS_CYC),
  parameter logic [31:0] UCD_WAIT_CYC  = 32'(`UCD_WAIT_CYC),
  parameter logic [31:0] RNG_WAIT_CYC  = 32'(`RNG_WAIT_CYC),
  parameter logic [31:0] REG_WAIT_CYC  = 32'(`REG_WAIT_CYC)
) (
  input  wire logic                  CLK,
  input  wire logic                  RST_N,
  // downstream frame destination
  input  wire logic                  DA_VALID,
  input  wire logic [47:0]           DA,
  input  wire logic [47:0]           OWN_MAC,
  output logic                       FRAME_VALID,
  output logic                       FRAME_ACCEPT,
  output logic                       FRAME_NO_BRIDGE,
  // transport stream in, MAC bytes out
  input  wire logic                  TS_VALID,
  input  wire logic                  TS_START,
  input  wire logic [7:0]            TS_BYTE,
  output logic                       TS_READY,
  output logic                       MAC_VALID,
  output logic [7:0]                 MAC_BYTE,
  input  wire logic                  MAC_READY,
  // MAP information elements
  input  wire logic                  IE_VALID,
  input  wire logic [13:0]           IE_SID,
  input  wire logic [3:0]            IE_IUC,
  input  wire logic [13:0]           IE_LEN,
  input  wire logic [13:0]           BURST_OFF,
  input  wire logic [13:0]           BURST_LEN,
  input  wire logic                  TX_PENDING,
  input  wire logic [2:0]            TX_PRIORITY,
  input  wire logic [NUM_SID*14-1:0] OWN_SIDS,
  input  wire logic [NUM_SID-1:0]    OWN_SID_VALID,
  output logic                       IE_OUT_VALID,
  output logic [2:0]                 IE_CLASS,
  output logic                       IE_TX_OK,
  output logic [3:0]                 IE_SLOT_LIMIT,
  output logic [13:0]                TX_SID,
  // protocol events and timers
  input  wire logic                  SYNC_RX,
  input  wire logic                  UCD_RX,
  input  wire logic                  UCD_WAIT_START,
  input  wire logic                  RNG_WAIT_START,
  input  wire logic                  REG_WAIT_START,
  input  wire logic                  REG_DONE,
  output logic                       SYNC_LOST,
  output logic                       UCD_TIMEOUT,
  output logic                       RNG_WAIT_TIMEOUT,
  output logic                       REG_TIMEOUT,
  output logic                       TX_INHIBIT,
  // retry accounting
  input  wire logic                  RNG_TIMEOUT_EV,
  input  wire logic                  RNG_OK,
  input  wire logic                  BW_TIMEOUT_EV,
  input  wire logic                  BW_OK,
  output logic                       RNG_FAILED,
  output logic                       BW_GAVE_UP
);

  // remainder of a by n, n in 1..14, by restoring division
  function automatic logic [3:0] mod_small(input logic [13:0] a, input logic [3:0] n);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 13; i >= 0; i--) begin
      r = {r[3:0], a[i]};
      if (r >= {1'b0, n}) r = r - {1'b0, n};
    end
    return r[3:0];
  endfunction

  // true when sid is one of the assigned unicast identifiers
  function automatic logic sid_is_mine(input logic [13:0]           sid,
                                       input logic [NUM_SID*14-1:0] tbl,
                                       input logic [NUM_SID-1:0]    vld);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_SID; i++) begin
      if (vld[i] && tbl[i*14 +: 14] == sid) hit = 1'b1;
    end
    return hit;
  endfunction

  cm_map_pkg::ts_state_t  ts_state_q;
  cm_map_pkg::sid_class_t cls;
  logic [7:0]  ts_idx_q;
  logic [4:0]  pid_hi_q;
  logic        pid_match_q;
  logic        ts_take;
  logic        fifo_push;
  logic        ok;
  logic [3:0]  lim;
  logic        addr_all;
  logic        addr_rsv;
  logic        addr_own;
  logic        addr_bcast;
  logic        rng_opp;
  logic [4:0]  rng_cnt_q;
  logic [4:0]  bw_cnt_q;
  logic [31:0] since_sync_q;

  // address decode; octets compared whole, group bit is first on the wire
  assign addr_all   = DA == `ADDR_ALL_CM; // see R3
  assign addr_rsv   = DA[`ADDR_GROUP_BIT] && DA >= `ADDR_RSV_LO && DA <= `ADDR_RSV_HI; // see R3
  assign addr_own   = DA == OWN_MAC;
  assign addr_bcast = &DA;

  // frame verdict, one cycle after the address
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      FRAME_VALID     <= 1'b0;
      FRAME_ACCEPT    <= 1'b0;
      FRAME_NO_BRIDGE <= 1'b0;
    end else begin
      FRAME_VALID     <= DA_VALID;
      FRAME_ACCEPT    <= DA_VALID && (addr_all || addr_own || addr_bcast); // see R1
      FRAME_NO_BRIDGE <= DA_VALID && (addr_all || addr_rsv); // see R2
    end
  end

  // a header byte also waits on the FIFO; simpler than a separate bypass
  assign ts_take   = TS_VALID && TS_READY;
  assign fifo_push = TS_VALID && !TS_START && ts_state_q == cm_map_pkg::TS_BODY && pid_match_q;

  // packet header walk; adaptation fields are passed through untouched
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ts_state_q  <= cm_map_pkg::TS_HUNT;
      ts_idx_q    <= 8'h00;
      pid_hi_q    <= 5'h00;
      pid_match_q <= 1'b0;
    end else if (ts_take) begin
      ts_idx_q <= ts_idx_q + 8'h01;
      if (TS_START) begin
        ts_idx_q    <= 8'h01;
        pid_match_q <= 1'b0;
        ts_state_q  <= (TS_BYTE == `TS_SYNC_BYTE) ? cm_map_pkg::TS_PID_HI : cm_map_pkg::TS_HUNT;
      end else begin
        case (ts_state_q)
          cm_map_pkg::TS_PID_HI: begin
            pid_hi_q   <= TS_BYTE[4:0];
            ts_state_q <= cm_map_pkg::TS_PID_LO;
          end
          cm_map_pkg::TS_PID_LO: begin
            pid_match_q <= {pid_hi_q, TS_BYTE} == `DATA_PID; // see R11
            ts_state_q  <= cm_map_pkg::TS_FLAGS;
          end
          cm_map_pkg::TS_FLAGS: begin
            ts_state_q <= cm_map_pkg::TS_BODY;
          end
          cm_map_pkg::TS_BODY: begin
            if (ts_idx_q == `TS_LAST_IDX) ts_state_q <= cm_map_pkg::TS_HUNT;
          end
          default: begin
            ts_state_q <= cm_map_pkg::TS_HUNT;
          end
        endcase
      end
    end
  end

  // payload buffer; a stalled consumer drops TS_READY back to the source
  stream_fifo #(
    .W     (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .rst_n     (RST_N),
    .in_valid  (fifo_push),
    .in_data   (TS_BYTE),
    .in_ready  (TS_READY),
    .out_valid (MAC_VALID),
    .out_data  (MAC_BYTE),
    .out_ready (MAC_READY)
  );

  // element classification by service ID
  always_comb begin
    cls = cm_map_pkg::SC_OTHER;
    ok  = 1'b0;
    lim = 4'h0;
    if (IE_SID == `SID_NONE) begin
      cls = cm_map_pkg::SC_NONE; // see R4
    end else if (IE_SID == `SID_ALL) begin
      cls = cm_map_pkg::SC_ALL;
      ok  = TX_PENDING; // see R6
    end else if (IE_SID >= `SID_MC_LO && IE_SID <= `SID_MC_HI) begin
      cls = cm_map_pkg::SC_MCAST;
      lim = IE_SID[3:0]; // see R8
      ok  = TX_PENDING && IE_IUC == IUC_REQ_DATA // see R7
            && BURST_LEN != 14'h0000 && BURST_LEN <= {10'h000, lim} // see R8
            && mod_small(BURST_OFF, lim) == 4'h0 // see R8
            && {1'b0, BURST_OFF} + {1'b0, BURST_LEN} <= {1'b0, IE_LEN};
    end else if (IE_SID[13:8] == `SID_PRIO_BLOCK) begin
      cls = cm_map_pkg::SC_PRIO;
      ok  = TX_PENDING && IE_IUC == IUC_REQUEST // see R9
            && IE_SID[TX_PRIORITY]; // see R10
    end else if (sid_is_mine(IE_SID, OWN_SIDS, OWN_SID_VALID)) begin
      cls = cm_map_pkg::SC_MINE;
      ok  = TX_PENDING; // see R23
    end
    if (TX_INHIBIT) ok = 1'b0;
  end

  // verdict one cycle after the element, far inside the map lead time
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      IE_OUT_VALID  <= 1'b0;
      IE_CLASS      <= 3'(cm_map_pkg::SC_NONE);
      IE_TX_OK      <= 1'b0;
      IE_SLOT_LIMIT <= 4'h0;
    end else begin
      IE_OUT_VALID  <= IE_VALID; // see R18
      IE_CLASS      <= 3'(cls);
      IE_TX_OK      <= IE_VALID && ok;
      IE_SLOT_LIMIT <= lim;
    end
  end

  // identity used in ranging: initialization SID until unicast SID entry 0 is valid
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      TX_SID <= `SID_INIT;
    end else begin
      TX_SID <= OWN_SID_VALID[0] ? OWN_SIDS[13:0] : `SID_INIT; // see R5
    end
  end

  // broadcast initial-maintenance opportunity ends the ranging wait
  assign rng_opp = IE_VALID && IE_SID == `SID_ALL && IE_IUC == IUC_INIT_MAINT;

  // sync supervision, re-armed by every sync message
  proto_timer u_sync_tmr (
    .clk     (CLK),
    .rst_n   (RST_N),
    .limit   (SYNC_LOSS_CYC), // see R15
    .start   (SYNC_RX),
    .stop    (1'b0),
    .expired (SYNC_LOST)
  );

  proto_timer u_descriptor_wait_timer (
    .clk     (CLK),
    .rst_n   (RST_N),
    .limit   (UCD_WAIT_CYC), // see R20
    .start   (UCD_WAIT_START),
    .stop    (UCD_RX),
    .expired (UCD_TIMEOUT)
  );

  proto_timer u_broadcast_ranging_wait_timer (
    .clk     (CLK),
    .rst_n   (RST_N),
    .limit   (RNG_WAIT_CYC), // see R21
    .start   (RNG_WAIT_START),
    .stop    (rng_opp),
    .expired (RNG_WAIT_TIMEOUT)
  );

  proto_timer u_registration_reply_wait_timer (
    .clk     (CLK),
    .rst_n   (RST_N),
    .limit   (REG_WAIT_CYC), // see R22
    .start   (REG_WAIT_START),
    .stop    (REG_DONE),
    .expired (REG_TIMEOUT)
  );

  // no upstream while timing or channel parameters are in doubt
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      TX_INHIBIT <= 1'b0;
    end else begin
      TX_INHIBIT <= SYNC_LOST || UCD_TIMEOUT;
    end
  end

  // ranging retries; a timeout in the same cycle as an OK wins
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rng_cnt_q  <= 5'h00;
      RNG_FAILED <= 1'b0;
    end else if (RNG_TIMEOUT_EV) begin
      if (rng_cnt_q == `RNG_RETRIES) begin
        RNG_FAILED <= 1'b1; // see R16
      end else begin
        rng_cnt_q <= rng_cnt_q + 5'h01;
      end
    end else if (RNG_OK) begin
      rng_cnt_q  <= 5'h00;
      RNG_FAILED <= 1'b0;
    end
  end

  // bandwidth request retries, same policy
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      bw_cnt_q   <= 5'h00;
      BW_GAVE_UP <= 1'b0;
    end else if (BW_TIMEOUT_EV) begin
      if (bw_cnt_q == `BW_RETRIES) begin
        BW_GAVE_UP <= 1'b1; // see R17
      end else begin
        bw_cnt_q <= bw_cnt_q + 5'h01;
      end
    end else if (BW_OK) begin
      bw_cnt_q   <= 5'h00;
      BW_GAVE_UP <= 1'b0;
    end
  end

  // cycles since the last sync, read only by the checks below
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      since_sync_q <= 32'h0000_0000;
    end else if (SYNC_RX) begin
      since_sync_q <= 32'h0000_0000;
    end else if (since_sync_q != 32'hffff_ffff) begin
      since_sync_q <= since_sync_q + 32'h0000_0001;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence s_ie_in;
    IE_VALID;
  endsequence
  sequence s_ie_out;
    IE_OUT_VALID;
  endsequence
  sequence s_last_rng_retry;
    RNG_TIMEOUT_EV && rng_cnt_q == `RNG_RETRIES;
  endsequence

  chk_all_cm_accept : // see R1
  assert property (DA_VALID && DA == `ADDR_ALL_CM |=> FRAME_ACCEPT && FRAME_NO_BRIDGE)
    else $error("all-modems frame not accepted");
  chk_reserved_local : // see R2
  assert property (DA_VALID && DA >= `ADDR_RSV_LO && DA <= `ADDR_RSV_HI |=> FRAME_NO_BRIDGE)
    else $error("reserved multicast frame allowed to bridge");
  chk_zero_sid_idle : // see R4
  assert property (IE_VALID && IE_SID == `SID_NONE |=> IE_OUT_VALID && !IE_TX_OK)
    else $error("transmit allowed on no-modem element");
  chk_init_sid_used : // see R5
  assert property (!OWN_SID_VALID[0] |=> TX_SID == `SID_INIT)
    else $error("unranged modem not using initialization SID");
  chk_bcast_open : // see R6
  assert property (IE_VALID && IE_SID == `SID_ALL && TX_PENDING && !TX_INHIBIT |=> IE_TX_OK)
    else $error("broadcast element not open to contention");
  chk_mcast_iuc : // see R7
  assert property (IE_TX_OK && IE_CLASS == 3'(cm_map_pkg::SC_MCAST) |-> $past(IE_IUC) == IUC_REQ_DATA)
    else $error("size-limited SID used outside request/data");
  chk_mcast_geometry : // see R8
  assert property (IE_TX_OK && IE_CLASS == 3'(cm_map_pkg::SC_MCAST)
                   |-> mod_small($past(BURST_OFF), IE_SLOT_LIMIT) == 4'h0
                       && $past(BURST_LEN) <= {10'h000, IE_SLOT_LIMIT})
    else $error("size-limited burst misplaced or too long");
  chk_prio_bit : // see R10
  assert property (IE_TX_OK && IE_CLASS == 3'(cm_map_pkg::SC_PRIO)
                   |-> $past(IE_SID[TX_PRIORITY]) && $past(IE_IUC) == IUC_REQUEST)
    else $error("priority request without permission");
  chk_pid_filter : // see R11
  assert property (fifo_push && TS_READY |-> pid_match_q && ts_state_q == cm_map_pkg::TS_BODY)
    else $error("byte of foreign PID entered the buffer");
  chk_sync_loss_time : // see R15
  assert property ($rose(SYNC_LOST) |-> since_sync_q == SYNC_LOSS_CYC)
    else $error("sync loss declared at the wrong time");
  chk_rng_retry_limit : // see R16
  assert property (s_last_rng_retry |=> RNG_FAILED)
    else $error("ranging failure not declared after last retry");
  chk_rng_not_early : // see R16
  assert property ($rose(RNG_FAILED) |-> $past(rng_cnt_q) == `RNG_RETRIES)
    else $error("ranging declared failed too early");
  chk_bw_not_early : // see R17
  assert property ($rose(BW_GAVE_UP) |-> $past(bw_cnt_q) == `BW_RETRIES)
    else $error("bandwidth request dropped too early");
  chk_map_latency : // see R18
  assert property (s_ie_in |-> ##1 s_ie_out)
    else $error("map element verdict late");

endmodule // cm_map_sid_decoder

`default_nettype wire

// File: verilog/cm_map_regs.svh
/*
  Constants for the cable-modem MAP / SID front end: well-known addresses,
  service ID values, transport PID, retry limits and protocol times.
  Assumes a 250 MHz MAC clock; cycle counts are derived from the period.
*/
`ifndef CM_MAP_REGS_SVH
`define CM_MAP_REGS_SVH

// clock
`define CLK_PERIOD_NS   64'd4
`define NS_PER_MS       64'd1000000

// MAC addresses, first octet in [47:40]; bit 40 is the first bit on the wire
`define ADDR_ALL_CM     48'h01e02f000001
`define ADDR_RSV_LO     48'h01e02f000002
`define ADDR_RSV_HI     48'h01e02f00000f
`define ADDR_GROUP_BIT  40

// service IDs (14 bits)
`define SID_NONE        14'h0000
`define SID_INIT        14'h0000
`define SID_ALL         14'h3fff
`define SID_MC_LO       14'h3ff1
`define SID_MC_HI       14'h3ffe
`define SID_PRIO_BLOCK  6'h3e

// transport stream
`define DATA_PID        13'h1ffe
`define TS_SYNC_BYTE    8'h47
`define TS_LAST_IDX     8'd187

// retry limits
`define RNG_RETRIES     5'd16
`define BW_RETRIES      5'd16

// protocol times in ms
`define SYNC_LOSS_MS    64'd600
`define UCD_INTERVAL_MS 64'd2000
`define RNG_INTERVAL_MS 64'd2000
`define WAIT_MULT       64'd5
`define REG_WAIT_MS     64'd3000

// longest times, rounded down to whole cycles
`define SYNC_LOSS_CYC   (`SYNC_LOSS_MS * `NS_PER_MS / `CLK_PERIOD_NS)
`define UCD_WAIT_CYC    (`WAIT_MULT * `UCD_INTERVAL_MS * `NS_PER_MS / `CLK_PERIOD_NS)
`define RNG_WAIT_CYC    (`WAIT_MULT * `RNG_INTERVAL_MS * `NS_PER_MS / `CLK_PERIOD_NS)
`define REG_WAIT_CYC    (`REG_WAIT_MS * `NS_PER_MS / `CLK_PERIOD_NS)

`endif

// File: verilog/cm_map_pkg.sv
/*
  Types shared by the MAP / SID front end.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cm_map_pkg;

  // class of a MAP information element, by its service ID
  typedef enum logic [2:0] {SC_NONE, SC_ALL, SC_MCAST, SC_PRIO, SC_MINE, SC_OTHER} sid_class_t;

  // transport packet header walk
  typedef enum logic [2:0] {TS_HUNT, TS_PID_HI, TS_PID_LO, TS_FLAGS, TS_BODY} ts_state_t;

endpackage

// File: verilog/stream_fifo.sv
/*
  Small first-word-fall-through FIFO with a registered output stage.
  Assumes one clock, synchronous active-low reset, DEPTH a power of two.
*/
`timescale 1ns/100ps
`default_nettype none

module stream_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16,
  localparam int AW   = $clog2(DEPTH)
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0]   count_q;
  logic [AW:0]   count_d;
  logic          push;
  logic          pop;

  // output stage refills whenever it is empty or being drained
  assign push = in_valid && in_ready;
  assign pop  = (count_q != '0) && (!out_valid || out_ready);

  // occupancy of the array, output stage not counted
  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (!push && pop) begin
      count_d = count_q - 1'b1;
    end
  end

  // pointers wrap naturally because DEPTH is a power of two
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
      count_q  <= count_d;
      in_ready <= count_d != (AW+1)'(DEPTH); // registered from count_d, so it drops in the cycle the array becomes full
    end
  end

  // storage carries no reset, it is never read before written
  always_ff @(posedge clk) begin
    if (push) mem[wr_ptr_q] <= in_data;
  end

  // registered output word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data  <= mem[rd_ptr_q];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule // stream_fifo

`default_nettype wire

// File: verilog/proto_timer.sv
/*
  One-shot protocol timer: start (re)arms, stop disarms, expired is a level.
  Assumes one clock and a synchronous active-low reset; limit is at least 1.
*/
`timescale 1ns/100ps
`default_nettype none

module proto_timer #(
  parameter int W = 32
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] limit,
  input  wire logic         start,
  input  wire logic         stop,
  output logic              expired
);

  logic [W-1:0] cnt_q;
  logic         run_q;

  // expired rises exactly limit cycles after the start edge; start beats stop
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q   <= '0;
      run_q   <= 1'b0;
      expired <= 1'b0;
    end else if (start) begin
      cnt_q   <= '0;
      run_q   <= 1'b1;
      expired <= 1'b0;
    end else if (stop) begin
      run_q   <= 1'b0;
      expired <= 1'b0;
    end else if (run_q) begin
      if (cnt_q == limit - 1'b1) begin
        run_q   <= 1'b0;
        expired <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

endmodule // proto_timer

`default_nettype wire

// File: test/mac_sink.sv
/* mac_sink: consumer of the payload byte stream, standing in for the MAC receive path.
   assumes one clock and the block's synchronous active-low reset. */
`timescale 1ns/100ps
`default_nettype none
module mac_sink (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       stall,
  input  wire logic       valid,
  input  wire logic [7:0] data,
  output logic            ready = 1'b0
);
  logic [7:0] got[$];
  // ready moves just after an edge, so a stall is seen for whole cycles
  always @(posedge clk) begin
    if (valid && ready && rst_n) got.push_back(data);
    ready <= rst_n && !stall;
  end
endmodule // mac_sink
`default_nettype wire

// File: test/cm_map_sid_decoder_bench.sv
/* bench: address, MAP element, retry, transport and timer tests.
   assumes the design files and mac_sink are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module cm_map_sid_decoder_bench;
  logic        CLK = 0, RST_N = 0, DA_VALID = 0, TS_VALID = 0, TS_START = 0, IE_VALID = 0;
  logic        TX_PENDING = 1, SYNC_RX = 0, UCD_RX = 0, UCD_WAIT_START = 0, RNG_WAIT_START = 0;
  logic        REG_WAIT_START = 0, REG_DONE = 0, RNG_TIMEOUT_EV = 0, RNG_OK = 0, stall = 1;
  logic        BW_TIMEOUT_EV = 0, BW_OK = 0, FRAME_VALID, FRAME_ACCEPT, FRAME_NO_BRIDGE;
  logic        TS_READY, MAC_VALID, MAC_READY, IE_OUT_VALID, IE_TX_OK, SYNC_LOST, UCD_TIMEOUT;
  logic        RNG_WAIT_TIMEOUT, REG_TIMEOUT, TX_INHIBIT, RNG_FAILED, BW_GAVE_UP;
  logic [47:0] DA = '0, OWN_MAC = 48'h02aabbccdd01;
  logic [7:0]  TS_BYTE = '0, MAC_BYTE;
  logic [13:0] IE_SID = '0, IE_LEN = '0, BURST_OFF = '0, BURST_LEN = '0, TX_SID;
  logic [3:0]  IE_IUC = '0, IE_SLOT_LIMIT, OWN_SID_VALID = '0;
  logic [2:0]  TX_PRIORITY = 3'h2, IE_CLASS;
  logic [55:0] OWN_SIDS = 56'h0123;
  int          n_mismatch = 0, cmp_count = 0;

  cm_map_sid_decoder #(.SYNC_LOSS_CYC(32'd20), .UCD_WAIT_CYC(32'd30), .RNG_WAIT_CYC(32'd30),
    .REG_WAIT_CYC(32'd25)) i_dut (.*);
  mac_sink i_sink (.clk(CLK), .rst_n(RST_N), .stall(stall), .valid(MAC_VALID),
    .data(MAC_BYTE), .ready(MAC_READY));

  always #2 CLK = ~CLK;

  task automatic chk(string name, logic [47:0] seen, logic [47:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one destination, answer one cycle later
  task automatic da_t(logic [47:0] a, logic acc, logic nb);
    @(negedge CLK);
    DA = a;
    DA_VALID = 1;
    @(negedge CLK);
    DA_VALID = 0;
    chk("frame_valid", FRAME_VALID, 1);
    chk("frame_accept", FRAME_ACCEPT, acc);
    chk("no_bridge", FRAME_NO_BRIDGE, nb);
  endtask

  // one MAP element, answer one cycle later
  task automatic ie_t(logic [13:0] sid, logic [3:0] iuc, logic [13:0] off, logic [13:0] bl,
                      logic [13:0] len, logic [2:0] cls, logic ok, logic [3:0] lim);
    @(negedge CLK);
    {IE_SID, IE_IUC, BURST_OFF, BURST_LEN, IE_LEN} = {sid, iuc, off, bl, len};
    IE_VALID = 1;
    @(negedge CLK);
    IE_VALID = 0;
    chk("ie_out_valid", IE_OUT_VALID, 1);
    chk("ie_class", IE_CLASS, cls);
    chk("ie_tx_ok", IE_TX_OK, ok);
    chk("slot_limit", IE_SLOT_LIMIT, lim);
  endtask

  // byte held until an edge sees ready; valid stays up for the next byte
  task automatic ts_t(logic [7:0] b, logic st);
    int k;
    @(negedge CLK);
    {TS_VALID, TS_START, TS_BYTE} = {1'b1, st, b};
    for (k = 0; k < 200 && TS_READY !== 1; k++) @(negedge CLK);
    if (k == 200) n_mismatch++;
  endtask

  initial begin
    #20000 n_mismatch++;
    print_verdict();
  end

  initial begin
    repeat (3) @(negedge CLK);
    RST_N = 1;
    @(negedge CLK);
    chk("tx_sid", TX_SID, 0);
    OWN_SID_VALID = 4'h1;
    repeat (2) @(negedge CLK);
    chk("tx_sid", TX_SID, 14'h0123);
    da_t(48'h01e02f000001, 1, 1);
    da_t(48'h01e02f000002, 0, 1);
    da_t(48'h01e02f00000f, 0, 1);
    da_t(48'h01e02f000010, 0, 0);
    da_t(48'h8007f4000080, 0, 0);
    da_t(OWN_MAC, 1, 0);
    $display("address test done");
    ie_t(14'h0000, 4'h1, 0, 1, 9, 0, 0, 0);
    ie_t(14'h3fff, 4'h1, 0, 1, 9, 1, 1, 0);
    ie_t(14'h3ff3, 4'h2, 3, 3, 9, 2, 1, 3);
    ie_t(14'h3ff3, 4'h2, 2, 3, 9, 2, 0, 3);
    ie_t(14'h3ff3, 4'h2, 3, 4, 9, 2, 0, 3);
    ie_t(14'h3ff3, 4'h1, 3, 3, 9, 2, 0, 3);
    ie_t(14'h3ffe, 4'h2, 0, 14, 14, 2, 1, 14);
    ie_t(14'h3e04, 4'h1, 0, 1, 9, 3, 1, 0);
    ie_t(14'h3efb, 4'h1, 0, 1, 9, 3, 0, 0);
    ie_t(14'h3e04, 4'h2, 0, 1, 9, 3, 0, 0);
    ie_t(14'h0123, 4'h2, 0, 1, 9, 4, 1, 0);
    ie_t(14'h0777, 4'h2, 0, 1, 9, 5, 0, 0);
    $display("element test done");
    repeat (17) begin
      @(negedge CLK);
      chk("rng_failed", RNG_FAILED, 0);
      chk("bw_gave_up", BW_GAVE_UP, 0);
      {RNG_TIMEOUT_EV, BW_TIMEOUT_EV} = 2'b11;
      @(negedge CLK);
      {RNG_TIMEOUT_EV, BW_TIMEOUT_EV} = 2'b00;
    end
    chk("rng_failed", RNG_FAILED, 1);
    chk("bw_gave_up", BW_GAVE_UP, 1);
    {RNG_OK, BW_OK} = 2'b11;
    @(negedge CLK);
    {RNG_OK, BW_OK} = 2'b00;
    @(negedge CLK);
    chk("retry_clear", {RNG_FAILED, BW_GAVE_UP}, 0);
    $display("retry test done");
    // data packet with the sink stalled until the buffer refuses
    ts_t(8'h47, 1);
    ts_t(8'h1f, 0);
    ts_t(8'hfe, 0);
    ts_t(8'h10, 0);
    for (int i = 0; i < 20; i++) begin
      if (i == 17) begin
        @(negedge CLK);
        TS_BYTE = 8'd17;
        repeat (3) @(negedge CLK);
        chk("ts_ready_full", TS_READY, 0);
        stall = 0;
      end
      ts_t(8'(i), 0);
    end
    // foreign PID, nothing of it may come out
    for (int i = 0; i < 8; i++) ts_t(i == 0 ? 8'h47 : (i == 2 ? 8'h11 : 8'ha5), i == 0);
    @(negedge CLK);
    TS_VALID = 0;
    repeat (40) @(negedge CLK);
    chk("mac_valid", MAC_VALID, 0);
    chk("byte_count", i_sink.got.size(), 20);
    foreach (i_sink.got[i]) chk("mac_byte", i_sink.got[i], i);
    $display("transport test done");
    @(negedge CLK);
    {SYNC_RX, UCD_WAIT_START, RNG_WAIT_START, REG_WAIT_START} = 4'hf;
    for (int k = 1; k <= 31; k++) begin
      @(negedge CLK);
      {SYNC_RX, UCD_WAIT_START, RNG_WAIT_START, REG_WAIT_START} = 4'h0;
      chk("sync_lost", SYNC_LOST, k > 20);
      chk("ucd_timeout", UCD_TIMEOUT, k > 30);
      chk("rng_wait", RNG_WAIT_TIMEOUT, k > 30);
      chk("reg_timeout", REG_TIMEOUT, k > 25);
    end
    ie_t(14'h3fff, 4'h1, 0, 1, 9, 1, 0, 0);
    // re-armed waits, each stopped by its own event before it runs out
    @(negedge CLK);
    {UCD_WAIT_START, RNG_WAIT_START, REG_WAIT_START} = 3'h7;
    @(negedge CLK);
    {UCD_WAIT_START, RNG_WAIT_START, REG_WAIT_START, UCD_RX, REG_DONE} = 5'h03;
    @(negedge CLK);
    {UCD_RX, REG_DONE} = 2'b00;
    ie_t(14'h3fff, 4'h3, 0, 1, 9, 1, 0, 0);
    repeat (35) @(negedge CLK);
    chk("ucd_stopped", UCD_TIMEOUT, 0);
    chk("rng_stopped", RNG_WAIT_TIMEOUT, 0);
    chk("reg_stopped", REG_TIMEOUT, 0);
    $display("timer test done");
    print_verdict();
  end
endmodule // cm_map_sid_decoder_bench
`default_nettype wire
